// File: test/ebpc_ext_model.sv
`timescale 1ns/1ps
// ==========================================
// far side: memory, i/o device and alternate bus master
module ebpc_ext_model (
	input wire logic core_clk,
	input wire logic own,
	input wire logic [23:0] x_addr,
	input wire logic x_mem_req_n,
	input wire logic x_io_req_n,
	input wire logic memory_request_n_out,
	input wire logic memory_request_n_oe,
	input wire logic io_request_n_out,
	input wire logic io_request_n_oe,
	input wire logic read_strobe_n_out,
	input wire logic read_strobe_n_oe,
	input wire logic write_strobe_n_out,
	input wire logic write_strobe_n_oe,
	input wire logic [23:0] external_location_bus_out,
	input wire logic external_location_bus_oe,
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_oe,
	output logic memory_request_n_in,
	output logic io_request_n_in,
	output logic [23:0] external_location_bus_in,
	output logic [7:0] data_bus_in
);
	logic [7:0] mem [256];
	logic [7:0] last = 8'h00;
	logic rd;
	logic wr;
	assign rd = read_strobe_n_oe & ~read_strobe_n_out;
	assign wr = write_strobe_n_oe & ~write_strobe_n_out;
	// request pins have pull-ups, so an undriven pin reads high
	assign memory_request_n_in = memory_request_n_oe ? memory_request_n_out :
		own ? x_mem_req_n : 1'b1;
	assign io_request_n_in = io_request_n_oe ? io_request_n_out :
		own ? x_io_req_n : 1'b1;
	// a released bus shows the inverse of its last level, never a stale copy
	assign external_location_bus_in = external_location_bus_oe ? external_location_bus_out :
		own ? x_addr : ~external_location_bus_out;
	assign data_bus_in = data_bus_oe ? data_bus_out : rd ? mem[external_location_bus_in[7:0]] : ~last;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = i[7:0] ^ 8'hA5;
		end
	end
	always @(posedge core_clk) begin
		last <= data_bus_in;
		if (wr && data_bus_oe) begin
			mem[external_location_bus_in[7:0]] <= data_bus_out;
		end
	end
endmodule : ebpc_ext_model

// File: test/external_bus_pin_control_tb_top.sv
`timescale 1ns/1ps
module external_bus_pin_control_tb_top;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic bus_ack = 1'b0;
	logic cpu_req = 1'b0;
	logic cpu_is_io = 1'b0;
	logic cpu_write = 1'b0;
	logic cpu_fetch = 1'b0;
	logic [23:0] cpu_addr = 24'h000000;
	logic [7:0] cpu_wdata = 8'h00;
	logic [7:0] cpu_rdata;
	logic cpu_done;
	// memory 0x10-0x1F w0, i/o 0x40-0x4F w2, memory 0x80 w7, select 3 off
	logic [3:0] cs_enable = 4'h7;
	logic [3:0] cs_is_io = 4'h2;
	logic [31:0] cs_lower = 32'h00804010;
	logic [31:0] cs_upper = 32'h00804F1F;
	logic [11:0] cs_waits = {3'h0, 3'h7, 3'h2, 3'h0};
	logic memory_request_n_in, memory_request_n_out, memory_request_n_oe;
	logic io_request_n_in, io_request_n_out, io_request_n_oe;
	logic read_strobe_n_out, read_strobe_n_oe, write_strobe_n_out, write_strobe_n_oe;
	logic instruction_read_n;
	logic [3:0] chip_select_n;
	logic [23:0] external_location_bus_in, external_location_bus_out;
	logic external_location_bus_oe;
	logic [7:0] data_bus_in, data_bus_out;
	logic data_bus_oe;
	logic own = 1'b0;
	logic [23:0] x_addr = 24'h000000;
	logic x_mem_req_n = 1'b1;
	logic x_io_req_n = 1'b1;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	ebpc_pins dut_u (.core_clk, .rst_b, .bus_ack, .cpu_req, .cpu_is_io, .cpu_write,
		.cpu_fetch, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_done, .cs_enable, .cs_is_io,
		.cs_lower, .cs_upper, .cs_waits, .memory_request_n_in, .memory_request_n_out,
		.memory_request_n_oe, .io_request_n_in, .io_request_n_out, .io_request_n_oe,
		.read_strobe_n_out, .read_strobe_n_oe, .write_strobe_n_out, .write_strobe_n_oe,
		.instruction_read_n, .chip_select_n, .external_location_bus_in,
		.external_location_bus_out, .external_location_bus_oe, .data_bus_in,
		.data_bus_out, .data_bus_oe);
	ebpc_ext_model ext_u (.core_clk, .own, .x_addr, .x_mem_req_n, .x_io_req_n,
		.memory_request_n_out, .memory_request_n_oe, .io_request_n_out, .io_request_n_oe,
		.read_strobe_n_out, .read_strobe_n_oe, .write_strobe_n_out, .write_strobe_n_oe,
		.external_location_bus_out, .external_location_bus_oe, .data_bus_out,
		.data_bus_oe, .memory_request_n_in, .io_request_n_in, .external_location_bus_in,
		.data_bus_in);
	// ==========================================
	// clock, timeout, checks
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	// ==========================================
	// one core access; for reads wd is the byte expected back
	task automatic access(input logic io, input logic wr, input logic fe,
		input logic [23:0] a, input logic [7:0] wd, input logic [3:0] cs, input int w);
		int n;
		@(negedge core_clk);
		cpu_is_io = io;
		cpu_write = wr;
		cpu_fetch = fe;
		cpu_addr = a;
		cpu_wdata = wd;
		cpu_req = 1'b1;
		@(negedge core_clk);
		chk(memory_request_n_out, io);
		chk(io_request_n_out, !io);
		chk(instruction_read_n, !fe);
		chk(external_location_bus_out, a);
		@(negedge core_clk);
		chk(read_strobe_n_out, wr);
		chk(write_strobe_n_out, !wr);
		chk(data_bus_oe, wr);
		chk(chip_select_n, cs);
		n = 2;
		while (cpu_done !== 1'b1 && n < 12) begin
			@(negedge core_clk);
			n++;
		end
		cpu_req = 1'b0;
		chk(n, 3 + w);
		if (wr) chk(ext_u.mem[a[7:0]], wd);
		else chk(cpu_rdata, wd);
		// done is a single-cycle pulse and the select lets go as the done cycle ends
		@(negedge core_clk);
		chk({cpu_done, chip_select_n, memory_request_n_out}, 6'h1F);
	endtask : access
	// ==========================================
	// outside master owns the pins; selects follow its levels
	task automatic ack_test();
		@(negedge core_clk);
		bus_ack = 1'b1;
		own = 1'b1;
		x_addr = 24'h123456;
		x_mem_req_n = 1'b0;
		#1;
		chk({memory_request_n_oe, io_request_n_oe, read_strobe_n_oe}, 3'h0);
		chk({write_strobe_n_oe, external_location_bus_oe, data_bus_oe}, 3'h0);
		@(negedge core_clk);
		chk(chip_select_n, 4'hE);
		x_addr = 24'h004700;
		x_mem_req_n = 1'b1;
		x_io_req_n = 1'b0;
		@(negedge core_clk);
		chk(chip_select_n, 4'hD);
		x_io_req_n = 1'b1;
		@(negedge core_clk);
		chk(chip_select_n, 4'hF);
		bus_ack = 1'b0;
		own = 1'b0;
	endtask : ack_test
	// ==========================================
	// grant arrives mid-read: cycle is dropped, the held request runs again after release
	task automatic abort_test();
		int n;
		@(negedge core_clk);
		cpu_is_io = 1'b0;
		cpu_write = 1'b0;
		cpu_fetch = 1'b0;
		cpu_addr = 24'h800005;
		cpu_req = 1'b1;
		repeat (3) @(negedge core_clk);
		bus_ack = 1'b1;
		#1;
		chk({read_strobe_n_oe, memory_request_n_oe, data_bus_oe}, 3'h0);
		@(negedge core_clk);
		chk({cpu_done, chip_select_n}, 5'h0F);
		@(negedge core_clk);
		chk({cpu_done, chip_select_n}, 5'h0F);
		bus_ack = 1'b0;
		n = 0;
		while (cpu_done !== 1'b1 && n < 12) begin
			@(negedge core_clk);
			n++;
		end
		cpu_req = 1'b0;
		chk(n, 3 + 7);
		chk(cpu_rdata, 8'hA0);
	endtask : abort_test
	initial begin
		repeat (16) @(negedge core_clk);
		chk({memory_request_n_oe, memory_request_n_in}, 2'h1);
		rst_b = 1'b1;
		chk(chip_select_n, 4'hF);
		access(1'b1, 1'b1, 1'b0, 24'h004533, 8'h5A, 4'hD, 2);
		access(1'b0, 1'b0, 1'b0, 24'h100033, 8'h5A, 4'hE, 0);
		access(1'b0, 1'b0, 1'b1, 24'h1F0001, 8'hA4, 4'hE, 0);
		access(1'b0, 1'b0, 1'b0, 24'h800002, 8'hA7, 4'hB, 7);
		access(1'b0, 1'b0, 1'b0, 24'h200004, 8'hA1, 4'hF, 0);
		abort_test();
		ack_test();
		access(1'b0, 1'b1, 1'b0, 24'h800009, 8'h3C, 4'hB, 7);
		report_and_stop();
	end
endmodule : external_bus_pin_control_tb_top

// File: verilog/ebpc_pins.sv
// What this block does
// - memory request low during memory access
// - read, write, fetch strobes qualify access
// - memory request undriven during reset
// - memory request is input under bus acknowledge
// - write strobe low; request pins pick space
// - write strobe tristated under bus acknowledge
// - read strobe low reading, tristated under acknowledge
// - four chip selects, each for its range
// - chip selects driven, decoded from pins always
// - location bus output normally, input under acknowledge
// - location pins feed chip select decode
// - per select wait states stretch accesses
// - data driven only on own write cycles
// - location bus is 24 bits wide
`timescale 1ns/1ps
module ebpc_pins (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic bus_ack,
	input wire logic cpu_req,
	input wire logic cpu_is_io,
	input wire logic cpu_write,
	input wire logic cpu_fetch,
	input wire logic [ebpc_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic [ebpc_pkg::DATA_W-1:0] cpu_wdata,
	output logic [ebpc_pkg::DATA_W-1:0] cpu_rdata,
	output logic cpu_done,
	input wire logic [ebpc_pkg::CS_NUM-1:0] cs_enable,
	input wire logic [ebpc_pkg::CS_NUM-1:0] cs_is_io,
	input wire logic [ebpc_pkg::CS_NUM*ebpc_pkg::RANGE_W-1:0] cs_lower,
	input wire logic [ebpc_pkg::CS_NUM*ebpc_pkg::RANGE_W-1:0] cs_upper,
	input wire logic [ebpc_pkg::CS_NUM*ebpc_pkg::WAIT_W-1:0] cs_waits,
	input wire logic memory_request_n_in,
	output logic memory_request_n_out,
	output logic memory_request_n_oe,
	input wire logic io_request_n_in,
	output logic io_request_n_out,
	output logic io_request_n_oe,
	output logic read_strobe_n_out,
	output logic read_strobe_n_oe,
	output logic write_strobe_n_out,
	output logic write_strobe_n_oe,
	output logic instruction_read_n,
	output logic [ebpc_pkg::CS_NUM-1:0] chip_select_n,
	input wire logic [ebpc_pkg::ADDR_W-1:0] external_location_bus_in,
	output logic [ebpc_pkg::ADDR_W-1:0] external_location_bus_out,
	output logic external_location_bus_oe,
	input wire logic [ebpc_pkg::DATA_W-1:0] data_bus_in,
	output logic [ebpc_pkg::DATA_W-1:0] data_bus_out,
	output logic data_bus_oe
);
	// ==========================================
	// bus cycle sequencer
	ebpc_pkg::ebpc_state_t state_r;
	ebpc_pkg::ebpc_state_t state_nxt;
	logic io_r;
	logic wr_r;
	logic fetch_r;
	logic [ebpc_pkg::ADDR_W-1:0] addr_r;
	logic [ebpc_pkg::DATA_W-1:0] cpu_wdata_r;
	logic [ebpc_pkg::WAIT_W-1:0] wait_r;
	logic [ebpc_pkg::CS_NUM-1:0] cs_hit;
	logic [ebpc_pkg::CS_NUM-1:0] cs_n_r;
	logic [ebpc_pkg::WAIT_W-1:0] hit_waits;
	logic active;
	logic strobing;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ebpc_pkg::ST_IDLE: begin
				if (cpu_req) begin
					state_nxt = ebpc_pkg::ST_ADDR;
				end
			end
			ebpc_pkg::ST_ADDR: begin
				state_nxt = ebpc_pkg::ST_STRB;
			end
			ebpc_pkg::ST_STRB: begin
				if (wait_r == ebpc_pkg::WAIT_RST) begin
					state_nxt = ebpc_pkg::ST_DONE;
				end
			end
			ebpc_pkg::ST_DONE: begin
				state_nxt = ebpc_pkg::ST_IDLE;
			end
		endcase
		// an outside master owns the pins: an unfinished cycle is dropped and retried later
		if (bus_ack) begin
			state_nxt = ebpc_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_r <= ebpc_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			addr_r <= ebpc_pkg::ADDR_RST;
			io_r <= 1'b0;
			wr_r <= 1'b0;
			fetch_r <= 1'b0;
		end else if (state_r == ebpc_pkg::ST_IDLE && cpu_req && !bus_ack) begin
			addr_r <= cpu_addr;
			io_r <= cpu_is_io;
			wr_r <= cpu_write;
			fetch_r <= cpu_fetch && !cpu_is_io;
		end
	end

	// wait count is loaded from the select that the address hits as the strobe opens
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wait_r <= ebpc_pkg::WAIT_RST;
		end else if (state_r == ebpc_pkg::ST_ADDR) begin
			wait_r <= hit_waits;
		end else if (state_r == ebpc_pkg::ST_STRB && wait_r != ebpc_pkg::WAIT_RST) begin
			wait_r <= wait_r - 3'h1;
		end
	end

	assign active = (state_r == ebpc_pkg::ST_ADDR) || (state_r == ebpc_pkg::ST_STRB);
	assign strobing = state_r == ebpc_pkg::ST_STRB;

	// ==========================================
	// pin drivers
	always_comb begin
		memory_request_n_out = !(active && !io_r);
		io_request_n_out = !(active && io_r);
		read_strobe_n_out = !(strobing && !wr_r);
		write_strobe_n_out = !(strobing && wr_r);
		instruction_read_n = !(active && fetch_r);
		external_location_bus_out = addr_r;
		data_bus_out = cpu_wdata_r;
	end

	// gating with the reset level keeps request pins off in the very first reset cycle
	assign memory_request_n_oe = rst_b && !bus_ack;
	assign io_request_n_oe = rst_b && !bus_ack;
	assign read_strobe_n_oe = !bus_ack;
	assign write_strobe_n_oe = !bus_ack;
	assign external_location_bus_oe = !bus_ack;
	assign data_bus_oe = strobing && wr_r && !bus_ack;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cpu_wdata_r <= ebpc_pkg::DATA_RST;
		end else if (state_r == ebpc_pkg::ST_IDLE && cpu_req && !bus_ack) begin
			cpu_wdata_r <= cpu_wdata;
		end
	end

	// ==========================================
	// read capture and completion
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cpu_rdata <= ebpc_pkg::DATA_RST;
		end else if (strobing && !wr_r && state_nxt == ebpc_pkg::ST_DONE) begin
			cpu_rdata <= data_bus_in;
		end
	end

	assign cpu_done = state_r == ebpc_pkg::ST_DONE;

	// ==========================================
	// chip select decode from the pin levels, whoever drives them
	logic [ebpc_pkg::ADDR_W-1:0] pin_addr;
	logic pin_mem_req_n;
	logic pin_io_req_n;
	logic [ebpc_pkg::CS_NUM-1:0] cs_in_range;

	assign pin_addr = bus_ack ? external_location_bus_in : addr_r;
	assign pin_mem_req_n = bus_ack ? memory_request_n_in : memory_request_n_out;
	assign pin_io_req_n = bus_ack ? io_request_n_in : io_request_n_out;

	for (genvar i = 0; i < ebpc_pkg::CS_NUM; i++) begin : g_cs
		logic [ebpc_pkg::RANGE_W-1:0] sel;
		logic [ebpc_pkg::RANGE_W-1:0] lo;
		logic [ebpc_pkg::RANGE_W-1:0] hi;
		assign lo = cs_lower[i*ebpc_pkg::RANGE_W +: ebpc_pkg::RANGE_W];
		assign hi = cs_upper[i*ebpc_pkg::RANGE_W +: ebpc_pkg::RANGE_W];
		assign sel = cs_is_io[i] ? pin_addr[ebpc_pkg::IO_RANGE_LSB +: ebpc_pkg::RANGE_W]
			: pin_addr[ebpc_pkg::MEM_RANGE_LSB +: ebpc_pkg::RANGE_W];
		assign cs_in_range[i] = cs_enable[i] && sel >= lo && sel <= hi
			&& (cs_is_io[i] ? !pin_io_req_n : !pin_mem_req_n);
	end

	// overlapping ranges: the lowest-numbered select wins so at most one asserts
	always_comb begin
		cs_hit = '0;
		hit_waits = ebpc_pkg::WAIT_RST;
		for (int k = ebpc_pkg::CS_NUM - 1; k >= 0; k--) begin
			if (cs_in_range[k]) begin
				cs_hit = '0;
				cs_hit[k] = 1'b1;
				hit_waits = cs_waits[k*ebpc_pkg::WAIT_W +: ebpc_pkg::WAIT_W];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cs_n_r <= ebpc_pkg::CS_N_RST;
		end else begin
			cs_n_r <= ~cs_hit;
		end
	end

	assign chip_select_n = cs_n_r;

	// ==========================================
	// checks
	property p_mem_req_float_reset;
		@(posedge core_clk) !rst_b |-> !memory_request_n_oe;
	endproperty
	a_mem_req_float_reset: assert property (p_mem_req_float_reset)
		else $error("memory request driven during reset");

	property p_ack_inputs;
		@(posedge core_clk) disable iff (!rst_b)
		bus_ack |-> !memory_request_n_oe && !io_request_n_oe && !external_location_bus_oe;
	endproperty
	a_ack_inputs: assert property (p_ack_inputs)
		else $error("request or location pins driven under bus acknowledge");

	property p_wr_tristate;
		@(posedge core_clk) disable iff (!rst_b) bus_ack |-> !write_strobe_n_oe;
	endproperty
	a_wr_tristate: assert property (p_wr_tristate)
		else $error("write strobe driven under bus acknowledge");

	property p_rd_strobe;
		@(posedge core_clk) disable iff (!rst_b)
		(state_r == ebpc_pkg::ST_ADDR && !wr_r && !bus_ack) |=> bus_ack
			|| (!read_strobe_n_out && read_strobe_n_oe && write_strobe_n_out);
	endproperty
	a_rd_strobe: assert property (p_rd_strobe)
		else $error("read strobe not low in read strobe phase");

	property p_mem_request;
		@(posedge core_clk) disable iff (!rst_b)
		(state_r == ebpc_pkg::ST_IDLE && cpu_req && !cpu_is_io && !bus_ack)
			|=> !memory_request_n_out && io_request_n_out || bus_ack;
	endproperty
	a_mem_request: assert property (p_mem_request)
		else $error("memory request not low for memory access");

	property p_data_write_only;
		@(posedge core_clk) disable iff (!rst_b)
		data_bus_oe |-> !write_strobe_n_out && !bus_ack;
	endproperty
	a_data_write_only: assert property (p_data_write_only)
		else $error("data bus driven outside own write");

	property p_cs_single;
		@(posedge core_clk) disable iff (!rst_b) $onehot0(~chip_select_n);
	endproperty
	a_cs_single: assert property (p_cs_single)
		else $error("more than one chip select low");

	property p_cs_from_pins;
		@(posedge core_clk) disable iff (!rst_b)
		(bus_ack && cs_enable[0] && !cs_is_io[0] && !memory_request_n_in
			&& external_location_bus_in[23:16] >= cs_lower[7:0]
			&& external_location_bus_in[23:16] <= cs_upper[7:0]) |=> !chip_select_n[0];
	endproperty
	a_cs_from_pins: assert property (p_cs_from_pins)
		else $error("chip select 0 not decoded from external pins");

	// a grant to the outside master aborts the cycle, so only an undisturbed access is held
	property p_wait_stretch;
		@(posedge core_clk) disable iff (!rst_b || bus_ack)
		(state_r == ebpc_pkg::ST_ADDR && hit_waits == 3'h2 && !bus_ack)
			|=> (state_r == ebpc_pkg::ST_STRB) [*3];
	endproperty
	a_wait_stretch: assert property (p_wait_stretch)
		else $error("two wait states did not stretch strobe to three cycles");

	c_read: cover property (@(posedge core_clk) disable iff (!rst_b)
		cpu_done && !wr_r);
	c_write: cover property (@(posedge core_clk) disable iff (!rst_b)
		cpu_done && wr_r);
	c_ack_cs: cover property (@(posedge core_clk) disable iff (!rst_b)
		bus_ack && chip_select_n != ebpc_pkg::CS_N_RST);
	c_waited: cover property (@(posedge core_clk) disable iff (!rst_b)
		strobing && wait_r != ebpc_pkg::WAIT_RST);
endmodule : ebpc_pins

// File: verilog/ebpc_pkg.sv
package ebpc_pkg;
	// ==========================================
	// pin widths
	localparam int ADDR_W = 24;
	localparam int DATA_W = 8;
	localparam int CS_NUM = 4;
	localparam int WAIT_W = 3;
	localparam int RANGE_W = 8;
	// ==========================================
	// range byte positions: memory ranges use the top byte, i/o ranges the middle byte
	localparam int MEM_RANGE_LSB = 16;
	localparam int IO_RANGE_LSB = 8;
	// ==========================================
	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [WAIT_W-1:0] WAIT_RST = 3'h0;
	localparam logic [CS_NUM-1:0] CS_N_RST = 4'hF;
	// ==========================================
	// bus cycle states, gray along idle-addr-strobe-done
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ADDR = 2'h1,
		ST_STRB = 2'h3,
		ST_DONE = 2'h2
	} ebpc_state_t;
endpackage : ebpc_pkg
